//--- design/dac_host_pkg.sv
// What this block does
// - data valid at falling serial clock edge
// - sixteen-bit words, host drives clock and frame
// - channel select gates frame to one channel
// - frame inputs active low, gate accordingly
// - don't-care bits shifted out first
// - converter LSB is last bit sent
// - byte mode: frame stays low across two bytes
// - frame high after second byte completes
// - frame low before clocking any data
// - update strobe may come from synchronised timer
package dac_host_pkg;

  // ----------------------------------------
  // framing
  // ----------------------------------------
  localparam int WORD_BITS    = 16;
  localparam int BYTE_BITS    = 8;
  localparam int CNT_W        = 5;
  localparam int DATA_W       = 14;

  // ----------------------------------------
  // timing, in clk_sys cycles at 20 MHz
  // ----------------------------------------
  localparam int SYS_NS       = 50;
  localparam int HALF_NS      = 200;
  localparam int HALF_CYC     = (HALF_NS + SYS_NS - 1) / SYS_NS;
  localparam int GAP_NS       = 400;
  localparam int GAP_CYC      = (GAP_NS + SYS_NS - 1) / SYS_NS;
  localparam int UPD_NS       = 200;
  localparam int UPD_CYC      = (UPD_NS + SYS_NS - 1) / SYS_NS;
  localparam int TMR_W        = 8;

  typedef enum logic [2:0]
  {
    ST_IDLE  = 3'b000,
    ST_SETUP = 3'b001,
    ST_HIGH  = 3'b010,
    ST_LOW   = 3'b011,
    ST_GAP   = 3'b100,
    ST_END   = 3'b101,
    ST_UPD   = 3'b110
  } state_e;

endpackage

//--- design/dac_serial_host.sv
`timescale 1ns/1ns
`default_nettype none
module dac_serial_host
#(
  parameter int FIFO_DEPTH = 32,
  parameter bit BYTE_MODE  = 1'b0,
  parameter bit TIMER_UPD  = 1'b0
)
(
  // clock and reset
  input  wire logic                           clk_sys,
  input  wire logic                           resetn,
  // word stream: {channel, signed sample}
  input  wire logic                           wr_chan_b,
  input  wire logic [dac_host_pkg::DATA_W-1:0] wr_sample,
  input  wire logic                           wr_valid,
  output logic                                wr_ready,
  // status
  output logic                                busy,
  // shared serial link
  output logic                                ser_clk,
  output logic                                ser_data,
  output logic                                channel_select,
  output logic                                frame_n_ch_a,
  output logic                                frame_n_ch_b,
  output logic                                update_n_ch_a,
  output logic                                update_n_ch_b
);
  localparam int FW = dac_host_pkg::DATA_W + 1;

  // ----------------------------------------
  // parameter checks
  // ----------------------------------------
  if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0)
  begin : g_bad_depth
    $error("fifo depth must be a power of two, at least two");
  end

  // phase counts must fit the shared timer or a phase would wrap
  if (dac_host_pkg::GAP_CYC > (1 << dac_host_pkg::TMR_W) || dac_host_pkg::HALF_CYC < 1)
  begin : g_bad_timer
    $error("timer too narrow for the phase counts");
  end

  // ----------------------------------------
  // buffering
  // ----------------------------------------
  logic [FW-1:0] f_data;
  logic          f_valid;
  logic          f_ready;

  word_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_fifo
  (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .in_data   ({wr_chan_b, wr_sample}),
    .in_valid  (wr_valid),
    .in_ready  (wr_ready),
    .out_data  (f_data),
    .out_valid (f_valid),
    .out_ready (f_ready)
  );

  // ----------------------------------------
  // serial engine
  // ----------------------------------------
  dac_host_pkg::state_e                 state_reg;
  logic [dac_host_pkg::WORD_BITS-1:0]   shift_reg;
  logic [dac_host_pkg::CNT_W-1:0]       bit_cnt_reg;
  logic [dac_host_pkg::TMR_W-1:0]       tmr_reg;
  logic                                 chan_reg;
  logic                                 tmr_done;

  assign tmr_done = tmr_reg == '0;
  assign f_ready  = (state_reg == dac_host_pkg::ST_IDLE);
  assign busy     = (state_reg != dac_host_pkg::ST_IDLE);

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg   <= dac_host_pkg::ST_IDLE;
      tmr_reg     <= '0;
      bit_cnt_reg <= '0;
    end
    else
    begin
      case (state_reg)
        dac_host_pkg::ST_IDLE:
        begin
          if (f_valid)
          begin
            state_reg   <= dac_host_pkg::ST_SETUP;
            tmr_reg     <= dac_host_pkg::TMR_W'(dac_host_pkg::HALF_CYC - 1);
            bit_cnt_reg <= '0;
          end
        end
        dac_host_pkg::ST_SETUP, dac_host_pkg::ST_GAP:
        begin
          if (tmr_done)
          begin
            state_reg <= dac_host_pkg::ST_HIGH;
            tmr_reg   <= dac_host_pkg::TMR_W'(dac_host_pkg::HALF_CYC - 1);
          end
          else
            tmr_reg <= tmr_reg - 1'b1;
        end
        dac_host_pkg::ST_HIGH:
        begin
          if (tmr_done)
          begin
            state_reg   <= dac_host_pkg::ST_LOW;
            tmr_reg     <= dac_host_pkg::TMR_W'(dac_host_pkg::HALF_CYC - 1);
            bit_cnt_reg <= bit_cnt_reg + 1'b1;
          end
          else
            tmr_reg <= tmr_reg - 1'b1;
        end
        dac_host_pkg::ST_LOW:
        begin
          if (!tmr_done)
            tmr_reg <= tmr_reg - 1'b1;
          else if (bit_cnt_reg == dac_host_pkg::CNT_W'(dac_host_pkg::WORD_BITS))
          begin
            state_reg <= dac_host_pkg::ST_END;
            tmr_reg   <= dac_host_pkg::TMR_W'(dac_host_pkg::HALF_CYC - 1);
          end
          // byte pause keeps the frame low between bytes
          else if (BYTE_MODE && bit_cnt_reg == dac_host_pkg::CNT_W'(dac_host_pkg::BYTE_BITS))
          begin
            state_reg <= dac_host_pkg::ST_GAP;
            tmr_reg   <= dac_host_pkg::TMR_W'(dac_host_pkg::GAP_CYC - 1);
          end
          else
          begin
            state_reg <= dac_host_pkg::ST_HIGH;
            tmr_reg   <= dac_host_pkg::TMR_W'(dac_host_pkg::HALF_CYC - 1);
          end
        end
        dac_host_pkg::ST_END:
        begin
          if (!tmr_done)
            tmr_reg <= tmr_reg - 1'b1;
          else if (TIMER_UPD)
          begin
            state_reg <= dac_host_pkg::ST_UPD;
            tmr_reg   <= dac_host_pkg::TMR_W'(dac_host_pkg::UPD_CYC - 1);
          end
          else
            state_reg <= dac_host_pkg::ST_IDLE;
        end
        dac_host_pkg::ST_UPD:
        begin
          if (tmr_done)
            state_reg <= dac_host_pkg::ST_IDLE;
          else
            tmr_reg <= tmr_reg - 1'b1;
        end
        default:
          state_reg <= dac_host_pkg::ST_IDLE;
      endcase
    end
  end

  // word layout: two don't-care zeros, then sample msb first, lsb last
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      shift_reg <= '0;
      chan_reg  <= 1'b0;
    end
    else if (state_reg == dac_host_pkg::ST_IDLE && f_valid)
    begin
      shift_reg <= {2'h0, f_data[dac_host_pkg::DATA_W-1:0]};
      chan_reg  <= f_data[FW-1];
    end
    else if (state_reg == dac_host_pkg::ST_LOW && tmr_done)
      shift_reg <= {shift_reg[dac_host_pkg::WORD_BITS-2:0], 1'b0};
  end

  // ----------------------------------------
  // pins, all from flip-flops
  // ----------------------------------------
  logic in_frame;
  assign in_frame = state_reg != dac_host_pkg::ST_IDLE && state_reg != dac_host_pkg::ST_UPD;

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      ser_clk        <= 1'b0;
      ser_data       <= 1'b0;
      channel_select <= 1'b0;
      frame_n_ch_a   <= 1'b1;
      frame_n_ch_b   <= 1'b1;
    end
    else
    begin
      // data changes on rising edge so it is stable at the falling one
      ser_clk        <= state_reg == dac_host_pkg::ST_HIGH;
      ser_data       <= shift_reg[dac_host_pkg::WORD_BITS-1];
      channel_select <= chan_reg;
      frame_n_ch_a   <= !(in_frame && !chan_reg);
      frame_n_ch_b   <= !(in_frame && chan_reg);
    end
  end

  // strobe tied low unless the timer pulse is chosen
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      update_n_ch_a <= 1'b1;
      update_n_ch_b <= 1'b1;
    end
    else
    begin
      update_n_ch_a <= TIMER_UPD ? !(state_reg == dac_host_pkg::ST_UPD && !chan_reg) : 1'b0;
      update_n_ch_b <= TIMER_UPD ? !(state_reg == dac_host_pkg::ST_UPD && chan_reg) : 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- design/word_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module word_fifo
#(
  parameter int WIDTH = 17,
  parameter int DEPTH = 32
)
(
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             resetn,
  // fill side
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  // drain side
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH)
  begin : g_bad_depth
    $error("word_fifo depth must be a power of two");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      rd_ptr_reg;
  logic             push;
  logic             pop;

  assign in_ready  = (wr_ptr_reg - rd_ptr_reg) != (AW+1)'(DEPTH);
  assign out_valid = wr_ptr_reg != rd_ptr_reg;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr_reg[AW-1:0]];

  always_ff @(posedge clk_sys)
  begin
    if (push)
      mem[wr_ptr_reg[AW-1:0]] <= in_data;
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      wr_ptr_reg <= '0;
    else if (push)
      wr_ptr_reg <= wr_ptr_reg + 1'b1;
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      rd_ptr_reg <= '0;
    else if (pop)
      rd_ptr_reg <= rd_ptr_reg + 1'b1;
  end
endmodule
`default_nettype wire

//--- tb/dac_chan_model.sv
`timescale 1ns/1ns
`default_nettype none
module dac_chan_model
(
  // serial port of one channel
  input wire logic        sclk,
  input wire logic        sdata,
  input wire logic        frame_n,
  input wire logic        update_n,
  // output latch
  output logic     [13:0] dac_out
);
  logic [15:0] shift_reg = 16'h0000;
  logic [4:0]  bit_cnt   = 5'h10;
  logic [13:0] in_latch  = 14'h0000;
  logic        dropped   = 1'b0;
  initial dac_out = 14'h0000;
  always @(negedge frame_n)
  begin
    bit_cnt = 5'h00;
    dropped = 1'b0;
  end
  always @(negedge sclk)
    if (!frame_n && bit_cnt < 5'h10)
    begin
      shift_reg = {shift_reg[14:0], sdata};
      bit_cnt = bit_cnt + 5'h01;
      if (bit_cnt == 5'h10)
      begin
        in_latch = shift_reg[13:0];
        if (!update_n && !dropped)
          dac_out = shift_reg[13:0];
      end
    end
  // strobe back high mid-load cancels it
  always @(posedge update_n)
    dropped = bit_cnt < 5'h10;
  always @(negedge update_n)
    if (bit_cnt == 5'h10)
      dac_out = in_latch;
endmodule
`default_nettype wire

//--- tb/dac_host_checker.sv
`timescale 1ns/1ns
`default_nettype none
module dac_host_checker
#(
  parameter bit TIMER_UPD = 1'b0
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // link and status
  input wire logic wr_ready,
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic channel_select,
  input wire logic frame_n_ch_a,
  input wire logic frame_n_ch_b,
  input wire logic update_n_ch_a,
  input wire logic update_n_ch_b
);
  // ----
  // falling edges in the open frame
  // ----
  logic       clk_q;
  logic [4:0] fall_cnt;
  wire        idle = frame_n_ch_a && frame_n_ch_b;
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn)
      clk_q <= 1'b0;
    else
      clk_q <= ser_clk;
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn)
      fall_cnt <= 5'h00;
    else if (idle)
      fall_cnt <= 5'h00;
    else if (clk_q && !ser_clk)
      fall_cnt <= fall_cnt + 5'h01;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  a_one_frame: assert property (idle || frame_n_ch_a || frame_n_ch_b) else $error("two frames low");
  a_select_a: assert property (!frame_n_ch_a |-> !channel_select) else $error("frame a bad select");
  a_select_b: assert property (!frame_n_ch_b |-> channel_select) else $error("frame b bad select");
  a_clk_framed: assert property (ser_clk |-> !idle) else $error("clock out of frame");
  a_data_steady: assert property ($fell(ser_clk) |-> $stable(ser_data)) else $error("data moved at fall");
  a_clk_high: assert property ($rose(ser_clk) |-> ser_clk[*4] ##1 !ser_clk) else $error("bad clock");
  a_word_len: assert property ($rose(idle) |-> fall_cnt == 5'h10) else $error("word not 16");
  a_no_extra: assert property (fall_cnt <= 5'h10) else $error("extra edges");
  a_dontcare_first: assert property ($fell(ser_clk) && fall_cnt < 5'h02 |-> !ser_data) else $error("pad");
  if (!TIMER_UPD)
  begin : g_tied
    a_update_tied: assert property ($past(resetn) |-> !update_n_ch_a) else $error("strobe high");
    a_update_b_tied: assert property ($past(resetn) |-> !update_n_ch_b) else $error("strobe b high");
  end
  else
  begin : g_timed
    a_pulse_idle: assert property ($fell(update_n_ch_a) |-> idle) else $error("pulse in frame");
    a_pulse_len: assert property ($fell(update_n_ch_a) |-> !update_n_ch_a[*4] ##1 update_n_ch_a)
      else $error("short pulse");
    c_pulse: cover property ($fell(update_n_ch_a));
  end
  c_word: cover property ($rose(idle));
  c_chan_b: cover property (!frame_n_ch_b);
  c_full: cover property (!wr_ready);
endmodule
`default_nettype wire

//--- tb/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic        clk_sys   = 1'b0;
  logic        resetn    = 1'b0;
  logic        wr_chan_b = 1'b0;
  logic [13:0] wr_sample = 14'h0000;
  logic        wr_valid  = 1'b0;
  wire         wr_ready, busy, ser_clk, ser_data, channel_select;
  wire         frame_n_ch_a, frame_n_ch_b, update_n_ch_a, update_n_ch_b;
  wire  [13:0] dac_a, dac_b;
  wire         busy_t, ser_clk_t, ser_data_t, frame_n_t_a, frame_n_t_b, update_n_t_a, update_n_t_b;
  wire  [13:0] dac_ta, dac_tb;
  int          err_count = 0;
  int          cmp_count = 0;
  initial forever #25 clk_sys = ~clk_sys;
  dac_serial_host #(.FIFO_DEPTH(32), .BYTE_MODE(1'b0), .TIMER_UPD(1'b0)) dut (.clk_sys(clk_sys), .resetn(resetn),
    .wr_chan_b(wr_chan_b), .wr_sample(wr_sample), .wr_valid(wr_valid), .wr_ready(wr_ready), .busy(busy),
    .ser_clk(ser_clk), .ser_data(ser_data), .channel_select(channel_select), .frame_n_ch_a(frame_n_ch_a),
    .frame_n_ch_b(frame_n_ch_b), .update_n_ch_a(update_n_ch_a), .update_n_ch_b(update_n_ch_b));
  // one model per channel, shared clock and data
  dac_chan_model chan_a (.sclk(ser_clk), .sdata(ser_data), .frame_n(frame_n_ch_a), .update_n(update_n_ch_a),
    .dac_out(dac_a));
  dac_chan_model chan_b (.sclk(ser_clk), .sdata(ser_data), .frame_n(frame_n_ch_b), .update_n(update_n_ch_b),
    .dac_out(dac_b));
  // second host in byte and timed-strobe mode, fed the same stream
  dac_serial_host #(.FIFO_DEPTH(32), .BYTE_MODE(1'b1), .TIMER_UPD(1'b1)) dut_tmr (.clk_sys(clk_sys),
    .resetn(resetn), .wr_chan_b(wr_chan_b), .wr_sample(wr_sample), .wr_valid(wr_valid), .wr_ready(),
    .busy(busy_t), .ser_clk(ser_clk_t), .ser_data(ser_data_t), .channel_select(), .frame_n_ch_a(frame_n_t_a),
    .frame_n_ch_b(frame_n_t_b), .update_n_ch_a(update_n_t_a), .update_n_ch_b(update_n_t_b));
  dac_chan_model chan_ta (.sclk(ser_clk_t), .sdata(ser_data_t), .frame_n(frame_n_t_a), .update_n(update_n_t_a),
    .dac_out(dac_ta));
  dac_chan_model chan_tb (.sclk(ser_clk_t), .sdata(ser_data_t), .frame_n(frame_n_t_b), .update_n(update_n_t_b),
    .dac_out(dac_tb));
  task automatic check(input logic [13:0] got, input logic [13:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("errors=%0d compares=%0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic push(input logic c, input logic [13:0] s, input int tries, output bit ok);
    wr_valid <= 1'b1;
    wr_chan_b <= c;
    wr_sample <= s;
    ok = 1'b0;
    for (int i = 0; i < tries && !ok; i++)
    begin
      @(negedge clk_sys);
      ok = (wr_ready === 1'b1);
      @(posedge clk_sys);
    end
    if (!ok && tries > 1)
    begin
      err_count++;
      test_done();
    end
  endtask
  // drain: fifo empty once busy stays low
  task automatic settle();
    int idle;
    idle = 0;
    wr_valid <= 1'b0;
    for (int i = 0; i < 9000 && idle < 20; i++)
    begin
      @(negedge clk_sys);
      idle = (busy === 1'b0 && busy_t === 1'b0) ? idle + 1 : 0;
    end
    if (idle < 20)
    begin
      err_count++;
      test_done();
    end
    @(posedge clk_sys);
  endtask
  task automatic t_single();
    bit ok;
    push(1'b0, 14'h1FFF, 400, ok);
    settle();
    check(dac_a, 14'h1FFF);
    check(dac_b, 14'h0000);
    check(dac_ta, 14'h1FFF);
    check(dac_tb, 14'h0000);
  endtask
  task automatic t_pair();
    bit ok;
    push(1'b1, 14'h2000, 400, ok);
    push(1'b0, 14'h0001, 400, ok);
    settle();
    check(dac_b, 14'h2000);
    check(dac_a, 14'h0001);
    check(dac_tb, 14'h2000);
    check(dac_ta, 14'h0001);
  endtask
  // pushing faster than the link drains until refused
  task automatic t_fill();
    int n;
    bit ok;
    n = 0;
    ok = 1'b1;
    while (ok && n < 40)
    begin
      push(n[0], 14'(n) + 14'h0100, 1, ok);
      n += int'(ok);
    end
    settle();
    check(14'(n), 14'h0021);
    check(n[0] ? dac_a : dac_b, 14'(n - 1) + 14'h0100);
    check(n[0] ? dac_b : dac_a, 14'(n - 2) + 14'h0100);
    check(n[0] ? dac_ta : dac_tb, 14'(n - 1) + 14'h0100);
    check(n[0] ? dac_tb : dac_ta, 14'(n - 2) + 14'h0100);
  endtask
  initial
  begin
    repeat (6) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    t_single();
    t_pair();
    t_fill();
    test_done();
  end
endmodule
bind dac_serial_host dac_host_checker #(.TIMER_UPD(TIMER_UPD)) chk (.clk_sys(clk_sys), .resetn(resetn),
  .wr_ready(wr_ready), .ser_clk(ser_clk), .ser_data(ser_data), .channel_select(channel_select),
  .frame_n_ch_a(frame_n_ch_a), .frame_n_ch_b(frame_n_ch_b), .update_n_ch_a(update_n_ch_a),
  .update_n_ch_b(update_n_ch_b));
`default_nettype wire
